// File: hw/adc_averaging_range_control.sv
// Purpose: Averages the ADC sample stream into tagged readings and drives range and calibration controls
// Assumes: One sample_valid pulse per conversion; software reaches control over AHB-Lite
// Notes: A reading carries the group sum and its sample count; the consumer divides
//
// Functional notes
// - Consecutive samples are summed in groups of averaging period times sample rate.
// - A period below 100 us counts as 100 us, so a group holds at least 25 samples.
// - Each reading carries a sequence count that rises by one per reading.
// - Readings go out at once and a new one replaces an untaken one without stalling.
// - Sixteen range codes combine four converters with four amplifier gains.
// - Input relays and output mux are driven together so one converter carries the signal.
// - Calibration current is off, on to the internal input, or on to the external circuit with loopback.
// - The low-value source is on exactly when one of the two most sensitive converters is selected.
// - With autoranging on, samples above 80% or below 20% of full scale are flagged with the reading.
// - For 1 ms after a range change starts, the last good reading is repeated.
`timescale 1ns/1ns
module adc_averaging_range_control #(
  parameter int unsigned MASK_CYCLES = adc_avg_pkg::MASK_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sample stream
  input wire logic sample_valid,
  input wire logic signed [15:0] sample_data,
  // Reading stream
  output logic reading_valid,
  input wire logic reading_ready,
  output logic [33:0] reading_sum,
  output logic [17:0] reading_count,
  output logic [15:0] reading_seq,
  output logic reading_over,
  output logic reading_under,
  output logic reading_masked,
  // Analog controls
  output logic [3:0] relay_sel,
  output logic [1:0] mux_sel,
  output logic [1:0] pga_gain_sel,
  output logic low_src_en,
  output logic cal_src_en,
  output logic cal_route_ext,
  // Interrupt
  output logic irq
);
  localparam int ACC_W = adc_avg_pkg::ACC_W;
  localparam int CNT_W = adc_avg_pkg::CNT_W;
  localparam int SEQ_W = adc_avg_pkg::SEQ_W;
  localparam int IRQ_W = adc_avg_pkg::IRQ_W;
  localparam logic [15:0] MASK_LAST = 16'(MASK_CYCLES - 1);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // Bus state
  logic take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_ctrl;
  logic wr_period;
  logic wr_clear;
  logic wr_enable;

  // Control registers
  logic run;
  logic auto_range;
  logic [3:0] range_cur;
  logic [1:0] cal_mode;
  logic loopback_option;
  logic [adc_avg_pkg::PERIOD_W-1:0] period_us;
  logic range_change;

  // Range mask sequencing
  adc_avg_pkg::range_state_t range_state;
  logic [adc_avg_pkg::MASK_W-1:0] mask_cnt;
  logic mask_done;
  logic masking;

  // Accumulation
  logic [27:0] scaled;
  logic [CNT_W-1:0] group_target;
  logic [CNT_W-1:0] group_len;
  logic [CNT_W-1:0] samp_cnt;
  logic signed [ACC_W-1:0] acc;
  logic grp_over;
  logic grp_under;
  logic first;
  logic last;
  logic [CNT_W-1:0] len_now;
  logic signed [ACC_W-1:0] next_acc;
  logic [16:0] mag;
  logic samp_over;
  logic samp_under;
  logic next_over;
  logic next_under;
  logic group_done;

  // Reading state
  logic [SEQ_W-1:0] seq;
  logic [ACC_W-1:0] good_sum;
  logic [CNT_W-1:0] good_count;

  // Interrupts
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;

  // Decoder results
  logic [3:0] dec_relay;
  logic [1:0] dec_mux;
  logic [1:0] dec_gain;
  logic dec_low;
  logic dec_cal_en;
  logic dec_cal_ext;

  // Zero wait state slave; hsize is not checked, only words are used
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = wr_pend && reg_hit(wr_addr, adc_avg_pkg::OFF_CTRL);
  assign wr_period = wr_pend && reg_hit(wr_addr, adc_avg_pkg::OFF_PERIOD);
  assign wr_clear = wr_pend && reg_hit(wr_addr, adc_avg_pkg::OFF_IRQ_CLEAR);
  assign wr_enable = wr_pend && reg_hit(wr_addr, adc_avg_pkg::OFF_IRQ_ENABLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= take && hwrite;
      if (take)
        wr_addr <= haddr[7:0];
    end
  end

  // Read data captured at the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        adc_avg_pkg::OFF_CTRL:
          hrdata <= {23'h000000, loopback_option, cal_mode, range_cur, auto_range, run};
        adc_avg_pkg::OFF_PERIOD:
          hrdata <= {12'h000, period_us};
        adc_avg_pkg::OFF_STATUS:
          hrdata <= {20'h00000, range_cur, 2'h0, low_src_en, reading_masked, reading_under,
                     reading_over, reading_valid, masking};
        adc_avg_pkg::OFF_SUM_LO:
          hrdata <= reading_sum[31:0];
        adc_avg_pkg::OFF_SUM_HI:
          hrdata <= {30'h00000000, reading_sum[33:32]};
        adc_avg_pkg::OFF_SEQ:
          hrdata <= {16'h0000, reading_seq};
        adc_avg_pkg::OFF_IRQ_STATUS:
          hrdata <= {27'h0000000, irq_status};
        adc_avg_pkg::OFF_IRQ_ENABLE:
          hrdata <= {27'h0000000, irq_enable};
        adc_avg_pkg::OFF_COUNT:
          hrdata <= {14'h0000, reading_count};
        default:
          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign range_change = wr_ctrl && (hwdata[adc_avg_pkg::CTRL_RANGE_LSB +: 4] != range_cur);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run <= 1'b0;
      auto_range <= 1'b0;
      range_cur <= adc_avg_pkg::RANGE_RESET;
      cal_mode <= adc_avg_pkg::CAL_OFF;
      loopback_option <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      run <= hwdata[adc_avg_pkg::CTRL_RUN_BIT];
      auto_range <= hwdata[adc_avg_pkg::CTRL_AUTO_BIT];
      range_cur <= hwdata[adc_avg_pkg::CTRL_RANGE_LSB +: 4];
      cal_mode <= hwdata[adc_avg_pkg::CTRL_CAL_LSB +: 2];
      loopback_option <= hwdata[adc_avg_pkg::CTRL_LB_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      period_us <= adc_avg_pkg::PERIOD_RESET;
    else if (wr_period)
      period_us <= hwdata[adc_avg_pkg::PERIOD_W-1:0];
  end

  range_decoder u_range_decoder (
    .range_code(range_cur),
    .cal_mode(cal_mode),
    .loopback_option(loopback_option),
    .relay_sel(dec_relay),
    .mux_sel(dec_mux),
    .pga_gain_sel(dec_gain),
    .low_src_en(dec_low),
    .cal_src_en(dec_cal_en),
    .cal_route_ext(dec_cal_ext)
  );

  // Relays and mux switch on the same edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      relay_sel <= 4'h1;
      mux_sel <= 2'h0;
      pga_gain_sel <= 2'h0;
      low_src_en <= 1'b1;
      cal_src_en <= 1'b0;
      cal_route_ext <= 1'b0;
    end
    else
    begin
      relay_sel <= dec_relay;
      mux_sel <= dec_mux;
      pga_gain_sel <= dec_gain;
      low_src_en <= dec_low;
      cal_src_en <= dec_cal_en;
      cal_route_ext <= dec_cal_ext;
    end
  end

  // Mask window after a range change
  assign masking = (range_state == adc_avg_pkg::RS_MASKING);
  assign mask_done = masking && !range_change && (mask_cnt == MASK_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      range_state <= adc_avg_pkg::RS_STEADY;
      mask_cnt <= 16'h0000;
    end
    else
    begin
      case (range_state)
        adc_avg_pkg::RS_STEADY:
        begin
          mask_cnt <= 16'h0000;
          if (range_change)
            range_state <= adc_avg_pkg::RS_MASKING;
        end
        adc_avg_pkg::RS_MASKING:
        begin
          // A further change restarts the full window
          if (range_change)
            mask_cnt <= 16'h0000;
          else if (mask_done)
            range_state <= adc_avg_pkg::RS_STEADY;
          else
            mask_cnt <= mask_cnt + 16'h0001;
        end
        default:
        begin
          range_state <= adc_avg_pkg::RS_STEADY;
          mask_cnt <= 16'h0000;
        end
      endcase
    end
  end

  always_comb
  begin
    // Group size from period and sample rate
    scaled = (28'(period_us) * 28'(adc_avg_pkg::SAMPLE_RATE_KHZ)) / 28'(1000);
    group_target = (scaled < 28'(adc_avg_pkg::MIN_GROUP)) ? adc_avg_pkg::MIN_GROUP : scaled[CNT_W-1:0];
    first = (samp_cnt == '0);
    len_now = first ? group_target : group_len;
    last = (samp_cnt == len_now - 18'h00001);
    // Fresh sum at group start, width covers the largest group
    next_acc = (first ? '0 : acc) + ACC_W'(sample_data);
    mag = sample_data[15] ? 17'(-$signed({sample_data[15], sample_data})) : {1'b0, sample_data};
    // Per-sample range flags in autorange mode
    samp_over = auto_range && (mag > adc_avg_pkg::OVER_LIMIT);
    samp_under = auto_range && (mag < adc_avg_pkg::UNDER_LIMIT);
    next_over = samp_over || (!first && grp_over);
    next_under = samp_under || (!first && grp_under);
    group_done = run && sample_valid && last;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      samp_cnt <= 18'h00000;
      group_len <= adc_avg_pkg::MIN_GROUP;
      acc <= 34'h000000000;
      grp_over <= 1'b0;
      grp_under <= 1'b0;
    end
    else if (!run)
    begin
      samp_cnt <= 18'h00000;
      acc <= 34'h000000000;
      grp_over <= 1'b0;
      grp_under <= 1'b0;
    end
    else if (sample_valid)
    begin
      acc <= next_acc;
      grp_over <= next_over;
      grp_under <= next_under;
      if (first)
        group_len <= group_target;
      samp_cnt <= last ? 18'h00000 : samp_cnt + 18'h00001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seq <= 16'h0000;
    else if (group_done)
      seq <= seq + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reading_valid <= 1'b0;
      reading_sum <= 34'h000000000;
      reading_count <= 18'h00000;
      reading_seq <= 16'h0000;
      reading_over <= 1'b0;
      reading_under <= 1'b0;
      reading_masked <= 1'b0;
      good_sum <= 34'h000000000;
      good_count <= 18'h00000;
    end
    else if (group_done)
    begin
      reading_valid <= 1'b1;
      reading_seq <= seq;
      // Repeat last good data while masking
      if (masking)
      begin
        reading_sum <= good_sum;
        reading_count <= good_count;
        reading_over <= 1'b0;
        reading_under <= 1'b0;
        reading_masked <= 1'b1;
      end
      else
      begin
        reading_sum <= next_acc;
        reading_count <= len_now;
        reading_over <= next_over;
        reading_under <= next_under;
        reading_masked <= 1'b0;
        good_sum <= next_acc;
        good_count <= len_now;
      end
    end
    else if (reading_ready)
      reading_valid <= 1'b0;
  end

  // Interrupt events; a set in the clearing cycle survives
  always_comb
  begin
    irq_event = '0;
    irq_event[adc_avg_pkg::IRQ_READING] = group_done;
    irq_event[adc_avg_pkg::IRQ_LOST] = group_done && reading_valid && !reading_ready;
    irq_event[adc_avg_pkg::IRQ_OVER] = group_done && !masking && next_over;
    irq_event[adc_avg_pkg::IRQ_UNDER] = group_done && !masking && next_under;
    irq_event[adc_avg_pkg::IRQ_RANGE] = mask_done;
    irq_clear = wr_clear ? hwdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= '0;
      irq_enable <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
      if (wr_enable)
        irq_enable <= hwdata[IRQ_W-1:0];
      irq <= |(((irq_status & ~irq_clear) | irq_event) & (wr_enable ? hwdata[IRQ_W-1:0] : irq_enable));
    end
  end
endmodule

// File: hw/adc_avg_pkg.sv
// Purpose: Shared constants and types for the sample averaging and range control block
// Assumes: 50 MHz hclk, 250 kHz sample stream, 32-bit AHB-Lite register bus
// Notes: Byte offsets are word aligned; upper address bits are not decoded
package adc_avg_pkg;
  // Widths
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 34;
  localparam int CNT_W = 18;
  localparam int PERIOD_W = 20;
  localparam int SEQ_W = 16;
  localparam int MASK_W = 16;
  localparam int IRQ_W = 5;

  // Timing
  localparam int CLK_MHZ = 50;
  localparam int SAMPLE_RATE_KHZ = 250;
  localparam int MIN_PERIOD_US = 100;
  localparam logic [CNT_W-1:0] MIN_GROUP = CNT_W'(MIN_PERIOD_US * SAMPLE_RATE_KHZ / 1000);
  localparam int MASK_TIME_US = 1000;
  localparam int MASK_CYCLES = MASK_TIME_US * CLK_MHZ;

  // Range flag limits, fractions of positive full scale
  localparam int FULL_SCALE = 32767;
  localparam int OVER_PCT = 80;
  localparam int UNDER_PCT = 20;
  localparam logic [SAMPLE_W:0] OVER_LIMIT = 17'(FULL_SCALE * OVER_PCT / 100);
  localparam logic [SAMPLE_W:0] UNDER_LIMIT = 17'(FULL_SCALE * UNDER_PCT / 100);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SUM_LO = 8'h0c;
  localparam logic [7:0] OFF_SUM_HI = 8'h10;
  localparam logic [7:0] OFF_SEQ = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;

  // Control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_RANGE_LSB = 2;
  localparam int CTRL_CAL_LSB = 6;
  localparam int CTRL_LB_BIT = 8;

  // Status fields
  localparam int STAT_MASK_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_OVER_BIT = 2;
  localparam int STAT_UNDER_BIT = 3;
  localparam int STAT_MASKED_BIT = 4;
  localparam int STAT_LOWSRC_BIT = 5;
  localparam int STAT_RANGE_LSB = 8;

  // Interrupt bits
  localparam int IRQ_READING = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_OVER = 2;
  localparam int IRQ_UNDER = 3;
  localparam int IRQ_RANGE = 4;

  // Reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 20'h00064;
  localparam logic [3:0] RANGE_RESET = 4'h0;

  typedef enum logic [1:0] {
    CAL_OFF = 2'h0,
    CAL_INTERNAL = 2'h1,
    CAL_EXTERNAL = 2'h2
  } cal_mode_t;

  typedef enum logic [1:0] {
    RS_STEADY = 2'b01,
    RS_MASKING = 2'b10
  } range_state_t;
endpackage

// File: hw/range_decoder.sv
// Purpose: Turns a range code and calibration mode into analog switch controls
// Assumes: Code bits [3:2] pick the converter, 0 the most sensitive; bits [1:0] pick gain x10/x5/x2/x1
// Notes: Purely combinational; the caller registers the outputs
`timescale 1ns/1ns
module range_decoder (
  // Selection
  input wire logic [3:0] range_code,
  input wire logic [1:0] cal_mode,
  input wire logic loopback_option,
  // Analog controls
  output logic [3:0] relay_sel,
  output logic [1:0] mux_sel,
  output logic [1:0] pga_gain_sel,
  output logic low_src_en,
  output logic cal_src_en,
  output logic cal_route_ext
);
  function automatic logic [3:0] one_hot(input logic [1:0] idx);
    one_hot = 4'h1 << idx;
  endfunction

  always_comb
  begin
    // Relays and mux from the same field so only one converter conducts
    relay_sel = one_hot(range_code[3:2]);
    mux_sel = range_code[3:2];
    pga_gain_sel = range_code[1:0];
    low_src_en = (range_code[3:2] < 2'h2);
    // External routing without the loopback option falls back to off
    cal_route_ext = (cal_mode == adc_avg_pkg::CAL_EXTERNAL) && loopback_option;
    cal_src_en = (cal_mode == adc_avg_pkg::CAL_INTERNAL) || cal_route_ext;
  end
endmodule

// File: verif/adc_avg_asserts.sv
// Purpose: Concurrent checks on the reading stream and analog control ports
// Assumes: Bound to the top module; one clock domain
// Notes: A reading completes only at an edge that takes a sample
`timescale 1ns/1ns
module adc_avg_asserts #(
  parameter int unsigned MASK_CYCLES = 50000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Streams
  input wire logic sample_valid,
  input wire logic reading_valid,
  input wire logic reading_ready,
  input wire logic [17:0] reading_count,
  input wire logic [15:0] reading_seq,
  input wire logic reading_over,
  input wire logic reading_under,
  input wire logic reading_masked,
  // Analog controls
  input wire logic [3:0] relay_sel,
  input wire logic [1:0] mux_sel,
  input wire logic low_src_en,
  input wire logic cal_src_en,
  input wire logic cal_route_ext
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_taken;
    reading_valid && reading_ready && !sample_valid;
  endsequence
  sequence s_fresh;
    $rose(reading_valid) && !reading_masked;
  endsequence

  a_relay_mux_pair: assert property (relay_sel == (4'h1 << mux_sel))
    else $error("relay select disagrees with mux select");
  a_low_src_sens: assert property (low_src_en == !mux_sel[1])
    else $error("low source enable wrong for converter");
  a_cal_ext_on: assert property (cal_route_ext |-> cal_src_en)
    else $error("external route without calibration current");
  a_group_min: assert property (s_fresh |-> reading_count >= 18'd25)
    else $error("reading from fewer than 25 samples");
  a_seq_step: assert property ($changed(reading_seq) |-> reading_seq == $past(reading_seq) + 16'h1)
    else $error("sequence count did not step by one");
  a_valid_holds: assert property (reading_valid && !reading_ready |=> reading_valid)
    else $error("untaken reading dropped");
  a_taken_drops: assert property (s_taken |=> !reading_valid)
    else $error("taken reading still offered");
  a_masked_noflag: assert property (reading_masked |-> !reading_over && !reading_under)
    else $error("masked reading carries range flags");
  a_masked_newseq: assert property ($rose(reading_masked) |-> $changed(reading_seq) || $rose(reading_valid))
    else $error("masked reading without new sequence count");
endmodule

// File: verif/adc_sample_source.sv
// Purpose: Behavioural ADC that feeds one sample pulse every GAP cycles
// Assumes: GAP of 200 gives 250 kHz at a 50 MHz clock
// Notes: Data line shows a toggling pattern between pulses
`timescale 1ns/1ns
module adc_sample_source #(
  parameter int GAP = 200
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Level to convert
  input wire logic signed [15:0] level,
  // Sample stream
  output logic sample_valid,
  output logic signed [15:0] sample_data
);
  int cnt;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 0;
      sample_valid <= 1'b0;
      sample_data <= 16'h0;
    end
    else
    begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == GAP - 1);
      sample_data <= (cnt == GAP - 1) ? level : ~sample_data;
    end
  end
endmodule

// File: verif/adc_averaging_range_control_test.sv
// Purpose: Self-checking bench for the averaging and range control block
// Assumes: One bus slave, hready fed from hreadyout
// Notes: Sample spacing and mask window shortened to keep the run brief
`timescale 1ns/1ns
module adc_averaging_range_control_test;
  localparam int unsigned MASK = 300;
  localparam int LIMIT = 20000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, reading_ready;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, mux_sel, pga_gain_sel;
  logic [2:0] hsize;
  logic sample_valid, reading_valid, reading_over, reading_under, reading_masked;
  logic signed [15:0] sample_data, level;
  logic [33:0] reading_sum;
  logic [17:0] reading_count;
  logic [15:0] reading_seq;
  logic [3:0] relay_sel;
  logic low_src_en, cal_src_en, cal_route_ext;
  logic [15:0] lv [4] = '{16'h7530, 16'h8ad0, 16'h0064, 16'h2710};
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  adc_averaging_range_control #(.MASK_CYCLES(MASK)) u_adc_averaging_range_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sample_valid(sample_valid), .sample_data(sample_data),
    .reading_valid(reading_valid), .reading_ready(reading_ready), .reading_sum(reading_sum),
    .reading_count(reading_count), .reading_seq(reading_seq), .reading_over(reading_over),
    .reading_under(reading_under), .reading_masked(reading_masked), .relay_sel(relay_sel),
    .mux_sel(mux_sel), .pga_gain_sel(pga_gain_sel), .low_src_en(low_src_en),
    .cal_src_en(cal_src_en), .cal_route_ext(cal_route_ext), .irq(irq));

  // Fast spacing so a group of 25 takes 100 cycles
  adc_sample_source #(.GAP(4)) u_sample_source (
    .hclk(hclk), .hresetn(hresetn), .level(level), .sample_valid(sample_valid),
    .sample_data(sample_data));

  task automatic summarize;
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(34'(q & m), 34'(e));
    chk(34'(hresp), 34'h0);
  endtask

  // Waits for a reading not seen before
  task automatic get_reading;
    logic [15:0] s;
    logic v;
    int n;
    #1;
    s = reading_seq;
    v = reading_valid;
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    while (!(reading_valid === 1'b1 && (v !== 1'b1 || reading_seq !== s)) && n < 3000);
    // A missing reading is a failure, not a silent skip
    if (n >= 3000)
    begin
      bad_count++;
      summarize();
    end
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      summarize();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reading_ready = 1'b0;
    level = 16'h0064;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(adc_avg_pkg::OFF_PERIOD, 32'h000fffff, 32'h00000064);
    rd(adc_avg_pkg::OFF_SEQ, 32'h0000ffff, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      wr(adc_avg_pkg::OFF_CTRL, 32'(c) << adc_avg_pkg::CTRL_RANGE_LSB);
      @(posedge hclk);
      #1;
      chk(34'(relay_sel), 34'(4'h1 << c[3:2]));
      chk(34'(mux_sel), 34'(c[3:2]));
      chk(34'(pga_gain_sel), 34'(c[1:0]));
      chk(34'(low_src_en), 34'(c < 8));
    end
    for (int m = 0; m < 8; m++)
    begin
      wr(adc_avg_pkg::OFF_CTRL, (32'(m[1:0]) << adc_avg_pkg::CTRL_CAL_LSB) | (32'(m[2]) << adc_avg_pkg::CTRL_LB_BIT));
      @(posedge hclk);
      #1;
      chk(34'(cal_src_en), 34'(m[1:0] == 2'h1 || (m[1:0] == 2'h2 && m[2])));
      chk(34'(cal_route_ext), 34'(m[1:0] == 2'h2 && m[2]));
    end
    repeat (MASK + 20) @(posedge hclk);
    wr(adc_avg_pkg::OFF_IRQ_ENABLE, 32'h1);
    wr(adc_avg_pkg::OFF_CTRL, 32'h1);
    get_reading();
    chk(34'(reading_count), 34'd25);
    chk(reading_sum, 34'd2500);
    chk(34'(reading_seq), 34'h0);
    @(posedge hclk);
    #1;
    chk(34'(irq), 34'h1);
    // Consumer stalls: the next reading must replace this one
    get_reading();
    chk(34'(reading_seq), 34'h1);
    rd(adc_avg_pkg::OFF_IRQ_STATUS, 32'h3, 32'h3);
    wr(adc_avg_pkg::OFF_CTRL, 32'h0);
    wr(adc_avg_pkg::OFF_IRQ_ENABLE, 32'h0);
    @(posedge hclk);
    #1;
    chk(34'(irq), 34'h0);
    wr(adc_avg_pkg::OFF_IRQ_CLEAR, 32'h1f);
    rd(adc_avg_pkg::OFF_IRQ_STATUS, 32'h1f, 32'h0);
    rd(8'h3c, 32'hffffffff, 32'h0);
    reading_ready <= 1'b1;
    wr(adc_avg_pkg::OFF_PERIOD, 32'd200);
    wr(adc_avg_pkg::OFF_CTRL, 32'h1);
    repeat (2)
    begin
      get_reading();
      chk(34'(reading_count), 34'd50);
      chk(reading_sum, 34'd5000);
    end
    rd(adc_avg_pkg::OFF_SUM_LO, 32'hffffffff, 32'd5000);
    rd(adc_avg_pkg::OFF_COUNT, 32'h0003ffff, 32'd50);
    wr(adc_avg_pkg::OFF_CTRL, 32'h0);
    wr(adc_avg_pkg::OFF_PERIOD, 32'd40);
    wr(adc_avg_pkg::OFF_CTRL, 32'h1);
    get_reading();
    chk(34'(reading_count), 34'd25);
    wr(adc_avg_pkg::OFF_CTRL, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      level <= lv[i];
      repeat (2) get_reading();
      chk(34'(reading_over), 34'(i < 2));
      chk(34'(reading_under), 34'(i == 2));
    end
    wr(adc_avg_pkg::OFF_CTRL, 32'h17);
    level <= 16'h4e20;
    rd(adc_avg_pkg::OFF_STATUS, 32'h00000f01, 32'h00000501);
    get_reading();
    chk(34'(reading_masked), 34'h1);
    chk(reading_sum, 34'd250000);
    repeat (5) get_reading();
    chk(34'(reading_masked), 34'h0);
    chk(reading_sum, 34'd500000);
    // Reset in mid-run must clear the sequence and the sum
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk(34'(reading_seq), 34'h0);
    chk(reading_sum, 34'h0);
    rd(adc_avg_pkg::OFF_CTRL, 32'h000001ff, 32'h0);
    summarize();
  end
endmodule

bind adc_averaging_range_control adc_avg_asserts #(.MASK_CYCLES(MASK_CYCLES)) u_adc_avg_asserts (
  .hclk(hclk), .hresetn(hresetn), .sample_valid(sample_valid), .reading_valid(reading_valid),
  .reading_ready(reading_ready), .reading_count(reading_count), .reading_seq(reading_seq),
  .reading_over(reading_over), .reading_under(reading_under), .reading_masked(reading_masked),
  .relay_sel(relay_sel), .mux_sel(mux_sel), .low_src_en(low_src_en), .cal_src_en(cal_src_en),
  .cal_route_ext(cal_route_ext));
